/* pkg/sirc_map.svh */
`ifndef SIRC_MAP_SVH
`define SIRC_MAP_SVH
// bit cell length in coding-clock periods
`define SIRC_CELL_TICKS 16
// encoder counter values at which the transmit pulse opens and closes
`define SIRC_PULSE_ON 4'h7
`define SIRC_PULSE_OFF 4'ha
// decoder low hold: reload value gives sixteen coding-clock periods of low
`define SIRC_RX_LOW_LAST 4'hf
// counter width shared by encoder and decoder
`define SIRC_CNT_W 4
// default depth and width of the receive event buffer
`define SIRC_BUF_DEPTH 2
`define SIRC_BUF_W 1
`endif

/* pkg/sirc_pkg.sv */
package sirc_pkg;
  // decoder state, one-hot
  typedef enum logic [1:0] {
    SIRC_DEC_IDLE = 2'b01,
    SIRC_DEC_LOW = 2'b10
  } sirc_dec_state_t;
endpackage

/* rtl/sirc_codec.sv */
`timescale 1ns/1ps
`include "sirc_map.svh"
module sirc_codec #(
  parameter int BUF_DEPTH = `SIRC_BUF_DEPTH, // receive event buffer entries
  parameter int BUF_W = `SIRC_BUF_W // receive event payload width
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sixteen_times_baud_clock_i,
  input wire logic serial_tx_data_i,
  input wire logic optical_pulse_rx_in_i,
  output logic optical_pulse_tx_out_o,
  output logic serial_rx_data_o,
  output logic rx_edge_ready_o
);
  localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CNT_W = $clog2(BUF_DEPTH + 1);

  // synchroniser stages, first stage read only by the second
  logic [1:0] cksync; // coding clock pin
  logic [1:0] txsync; // uart transmit pin
  logic [1:0] rxsync; // optical receive pin
  logic ck_prev; // last synced coding clock level
  logic rx_prev; // last synced receive level
  logic rise_tick; // coding clock rising edge, one cycle
  logic fall_tick; // coding clock falling edge, one cycle
  logic rx_edge; // falling edge seen on the receive line

  // encoder state
  logic [`SIRC_CNT_W-1:0] enc_cnt;
  logic tx_out;

  // decoder state
  sirc_pkg::sirc_dec_state_t dec_state;
  logic [`SIRC_CNT_W-1:0] dec_cnt;
  logic rx_out;

  // event buffer
  logic [BUF_W-1:0] buf_mem [BUF_DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] buf_cnt;
  logic buf_in_valid; // filling side valid
  logic buf_in_ready; // filling side ready
  logic buf_out_valid; // draining side valid
  logic buf_out_ready; // draining side ready
  logic [BUF_W-1:0] buf_out_data;
  logic push;
  logic pop;

  // two flops on every pin before any logic looks at it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cksync <= 2'h0;
      txsync <= 2'h3; // idle uart line is high
      rxsync <= 2'h3;
    end else begin
      cksync <= {cksync[0], sixteen_times_baud_clock_i};
      txsync <= {txsync[0], serial_tx_data_i};
      rxsync <= {rxsync[0], optical_pulse_rx_in_i};
    end
  end

  // edge history on the synced copies only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ck_prev <= 1'b0;
      rx_prev <= 1'b1;
    end else begin
      ck_prev <= cksync[1];
      rx_prev <= rxsync[1];
    end
  end

  // the coding clock is not a clock here: its edges become enables
  assign rise_tick = cksync[1] & ~ck_prev;
  assign fall_tick = ~cksync[1] & ck_prev;
  // falling edge only: a negative pulse is caught at its leading edge,
  // a positive one at its trailing edge, both land in the same cell
  assign rx_edge = rx_prev & ~rxsync[1];

  // encoder: counter on coding clock falling edges, no word framing kept
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      enc_cnt <= '0;
    end else if (fall_tick) begin
      if (txsync[1]) begin
        enc_cnt <= '0;
      end else begin
        // four-bit wrap keeps pulses on the bit cell grid
        enc_cnt <= enc_cnt + `SIRC_CNT_W'(1);
      end
    end
  end

  // encoder output: open at count seven, close at count ten
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_out <= 1'b0;
    end else if (fall_tick) begin
      if (txsync[1]) begin
        tx_out <= 1'b0;
      end else if (enc_cnt + `SIRC_CNT_W'(1) == `SIRC_PULSE_ON) begin
        tx_out <= 1'b1;
      end else if (enc_cnt + `SIRC_CNT_W'(1) == `SIRC_PULSE_OFF) begin
        tx_out <= 1'b0;
      end
    end
  end

  assign optical_pulse_tx_out_o = tx_out;

  // event buffer: edges arrive at the fast clock, are used on rising ticks
  assign buf_in_valid = rx_edge;
  assign buf_in_ready = (buf_cnt != CNT_W'(BUF_DEPTH));
  assign buf_out_valid = (buf_cnt != '0);
  // the decoder only drains on a rising tick, so the buffer really stalls
  assign buf_out_ready = rise_tick;
  assign push = buf_in_valid & buf_in_ready;
  assign pop = buf_out_valid & buf_out_ready;
  assign buf_out_data = buf_mem[rd_ptr];
  assign rx_edge_ready_o = buf_in_ready;

  // storage, one flop set per entry
  for (genvar i = 0; i < BUF_DEPTH; i++) begin : g_entry
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        buf_mem[i] <= '0;
      end else if (push && wr_ptr == PTR_W'(i)) begin
        buf_mem[i] <= {BUF_W{1'b1}}; // marks a received zero
      end
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      buf_cnt <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_W'(BUF_DEPTH - 1)) ? '0 : wr_ptr + PTR_W'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_W'(BUF_DEPTH - 1)) ? '0 : rd_ptr + PTR_W'(1);
      end
      if (push && !pop) begin
        buf_cnt <= buf_cnt + CNT_W'(1);
      end else if (pop && !push) begin
        buf_cnt <= buf_cnt - CNT_W'(1);
      end
    end
  end

  // decoder machine: every event starts a fresh sixteen-tick low
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dec_state <= sirc_pkg::SIRC_DEC_IDLE;
      dec_cnt <= '0;
      rx_out <= 1'b1;
    end else if (pop && buf_out_data[0]) begin
      // an edge during a low restarts it; a late edge leaves a glitch
      dec_state <= sirc_pkg::SIRC_DEC_LOW;
      dec_cnt <= `SIRC_RX_LOW_LAST;
      rx_out <= 1'b0;
    end else if (rise_tick) begin
      case (dec_state)
        sirc_pkg::SIRC_DEC_LOW: begin
          if (dec_cnt == '0) begin
            dec_state <= sirc_pkg::SIRC_DEC_IDLE;
            rx_out <= 1'b1;
          end else begin
            dec_cnt <= dec_cnt - `SIRC_CNT_W'(1);
          end
        end
        default: begin
          rx_out <= 1'b1;
          dec_state <= sirc_pkg::SIRC_DEC_IDLE;
        end
      endcase
    end
  end

  assign serial_rx_data_o = rx_out;

  // steps of a transmit pulse, on falling ticks of the coding clock, and the start of a receive low
  sequence s_open_tick;
    fall_tick && !txsync[1] && enc_cnt == 4'h6;
  endsequence

  sequence s_close_tick;
    fall_tick && !txsync[1] && enc_cnt == 4'h9;
  endsequence

  sequence s_low_start;
    pop && buf_out_data[0];
  endsequence

  tx_idle_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fall_tick && txsync[1] |=> !tx_out && enc_cnt == 4'h0)
    else $error("tx idle did not clear");

  tx_pulse_open_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_open_tick |=> tx_out && enc_cnt == 4'h7)
    else $error("tx pulse did not open at seven");

  tx_pulse_close_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_close_tick |=> !tx_out && enc_cnt == 4'ha)
    else $error("tx pulse did not close at ten");

  tx_pulse_stable_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !fall_tick |=> $stable(tx_out))
    else $error("tx output moved off a falling tick");

  tx_count_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fall_tick && !txsync[1] && enc_cnt == 4'hf |=> enc_cnt == 4'h0 && !tx_out)
    else $error("tx counter did not wrap");

  rx_reset_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> rx_out && dec_cnt == 4'h0)
    else $error("rx not high after reset");

  rx_edge_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_low_start |=> !rx_out && dec_cnt == 4'hf)
    else $error("rx did not fall on event");

  rx_hold_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rise_tick && dec_state == sirc_pkg::SIRC_DEC_LOW && dec_cnt != 4'h0 |=> !rx_out)
    else $error("rx low ended early");

  rx_return_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rise_tick && dec_state == sirc_pkg::SIRC_DEC_LOW && dec_cnt == 4'h0 && !(pop && buf_out_data[0])
    |=> rx_out)
    else $error("rx did not return high");

  rx_idle_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
    dec_state == sirc_pkg::SIRC_DEC_IDLE |-> rx_out)
    else $error("rx low while idle");

  rx_edge_queued_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_edge && buf_in_ready |=> buf_cnt != '0)
    else $error("receive edge not queued");
endmodule

/* verif/sirc_far.sv */
`timescale 1ns/1ps
// far side: uart giving the coding clock, plus optical transceiver
module sirc_far (
  input wire logic clk_i,
  output logic cclk_o,
  output logic tx_o,
  output logic ir_o
);
  int dv = 0; // clk_i count within half a coding period
  // coding clock of 8 clk_i periods, free running like a baud output
  initial begin
    cclk_o = 1'b0;
    tx_o = 1'b1; // uart line idles at one
    ir_o = 1'b1;
    forever begin
      @(posedge clk_i);
      #1;
      dv = (dv + 1) % 4;
      if (dv == 0) cclk_o = ~cclk_o;
    end
  end
  // hold the uart line for n coding clocks, changes on a rise
  task automatic hold(input logic v, input int n);
    @(posedge cclk_o);
    tx_o = v;
    repeat (n - 1) @(posedge cclk_o);
  endtask
  // framed word, low bit first, same rate both ends
  task automatic word(input logic [9:0] f);
    for (int i = 0; i < 10; i++) hold(f[i], 16);
  endtask
  // receive idle level for pulse polarity p
  task automatic idle(input logic p);
    ir_o = ~p;
  endtask
  // three-clock pulse of level p in each zero cell
  task automatic optic(input logic [9:0] f, input logic p);
    for (int i = 0; i < 160; i++) begin
      @(posedge cclk_o);
      ir_o = (!f[i/16] && i % 16 > 5 && i % 16 < 9) ? p : ~p;
    end
  endtask
  // edges faster than the buffer drains: deliberately abusive
  task automatic burst();
    repeat (4) begin
      @(posedge clk_i);
      #1 ir_o = 1'b0;
      @(posedge clk_i);
      #1 ir_o = 1'b1;
    end
  endtask
endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ps
// codec bench: coding clock, uart and optical inputs come from the far-side model
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1; // held from time zero
  wire cclk, utx, irx;
  logic optical_pulse_tx_out_o, serial_rx_data_o, rx_edge_ready_o;
  int failures = 0;
  int compares = 0;
  int seed = 32'h90ed85d9; // fixed so runs repeat
  int cyc = 0, tf = 0, np = 0, w = 0, lw = 0, lo = 0, ll = 0;
  bit chk = 1'b1; // pulse place and width checked
  bit nr = 1'b0; // buffer seen full
  logic ptx = 1'b1;
  logic [9:0] f, g;
  logic [7:0] d;
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  sirc_codec sirc_codec_i (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sixteen_times_baud_clock_i(cclk),
    .serial_tx_data_i(utx),
    .optical_pulse_rx_in_i(irx),
    .optical_pulse_tx_out_o(optical_pulse_tx_out_o),
    .serial_rx_data_o(serial_rx_data_o),
    .rx_edge_ready_o(rx_edge_ready_o)
  );
  sirc_far sirc_far_i (
    .clk_i(clk_i),
    .cclk_o(cclk),
    .tx_o(utx),
    .ir_o(irx)
  );
  task automatic check(input bit ok, input string m);
    compares++;
    if (!ok) begin
      failures++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // zeros in a framed word, one pulse expected for each
  function automatic int exp_pulses(input logic [9:0] v);
    int n;
    n = 0;
    for (int i = 0; i < 10; i++) begin
      if (!v[i]) n++;
    end
    return n;
  endfunction
  // uart receiver: start fall, then mid-bit samples
  task automatic urx(output logic [9:0] r);
    int n;
    n = 0;
    // looks just after each edge, where the outputs have settled
    while (serial_rx_data_o !== 1'b0 && n < 3000) begin
      tick(1);
      n++;
    end
    tick(64);
    for (int i = 0; i < 10; i++) begin
      r[i] = serial_rx_data_o;
      tick(128);
    end
  endtask
  // watcher: pulse place from last line fall, widths, low runs
  // runs on the falling edge so it never races the design's updates
  always @(negedge clk_i) begin
    cyc++;
    if (ptx && !utx) tf = cyc;
    ptx = utx;
    if (rx_edge_ready_o === 1'b0) nr = 1'b1;
    if (serial_rx_data_o === 1'b0) lo++;
    else if (lo != 0) begin
      ll = lo;
      lo = 0;
    end
    if (optical_pulse_tx_out_o === 1'b1) begin
      if (w == 0) np++;
      if (w == 0 && chk) check((cyc - tf) % 128 > 51 && (cyc - tf) % 128 < 61, "pulse place");
      w++;
    end else if (w != 0) begin
      lw = w;
      w = 0;
      if (chk) check(lw == 24, "pulse width");
    end
  end
  initial begin
    tick(2);
    check(optical_pulse_tx_out_o === 1'b0 && serial_rx_data_o === 1'b1 && rx_edge_ready_o === 1'b1, "reset");
    tick(3);
    rst_i = 1'b0;
    // corner words first, then random ones
    for (int k = 0; k < 6; k++) begin
      d = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($random(seed));
      f = {1'b1, d, 1'b0};
      np = 0;
      sirc_far_i.word(f);
      tick(40);
      check(np == exp_pulses(f), "pulse count");
    end
    $display("test encode done");
    // line back high in mid-pulse cuts the pulse short
    chk = 1'b0;
    lw = 0;
    sirc_far_i.hold(1'b0, 8);
    sirc_far_i.hold(1'b1, 16);
    check(lw > 0 && lw < 24 && optical_pulse_tx_out_o === 1'b0, "abort");
    fork
      sirc_far_i.hold(1'b0, 16);
      begin
        tick(60);
        rst_i = 1'b1;
        tick(2);
        check(optical_pulse_tx_out_o === 1'b0 && serial_rx_data_o === 1'b1, "mid reset");
        rst_i = 1'b0;
      end
    join
    sirc_far_i.hold(1'b1, 16);
    $display("test abort done");
    // both polarities alternate; idle change settles first
    for (int k = 0; k < 6; k++) begin
      d = (k == 0) ? 8'hff : 8'($random(seed));
      f = {1'b1, d, 1'b0};
      sirc_far_i.idle(k[0]);
      tick(300);
      check(serial_rx_data_o === 1'b1, "rx idle");
      fork
        sirc_far_i.optic(f, k[0]);
        urx(g);
      join
      check(g === f, "decoded word");
      if (k == 0) check(ll == 128, "low length");
    end
    sirc_far_i.idle(1'b0);
    tick(300);
    nr = 1'b0;
    sirc_far_i.burst();
    tick(300);
    check(nr && rx_edge_ready_o === 1'b1 && serial_rx_data_o === 1'b1, "buffer");
    $display("test decode done");
    conclude();
  end
  initial begin
    #200000;
    failures++;
    $display("mismatch at %0t: watchdog", $time);
    conclude();
  end
endmodule
